// >>> hw/rmp_pkg.sv
/*
  constants for the regulator margin and power-save register bank.
  assumes a byte-wide register write/read port driven by a serial engine.
*/
package rmp_pkg;
  // register indices
  localparam logic [7:0] IDX_NB_MARGIN = 8'h00;
  localparam logic [7:0] IDX_CORE_MARGIN = 8'h01;
  localparam logic [7:0] IDX_POWER_SAVE = 8'h02;
  // reset values
  localparam logic [7:0] RST_NB_MARGIN = 8'h00;
  localparam logic [7:0] RST_CORE_MARGIN = 8'h00;
  localparam logic [7:0] RST_POWER_SAVE = 8'h01;
  // margin fields
  localparam int MRG_OVP_BIT = 7;
  localparam int MRG_PG_BIT = 6;
  localparam int MRG_OFS_MSB = 5;
  // power-save fields
  localparam int PS_RSVD_BIT = 7;
  localparam int PS_OFS_DIS_BIT = 6;
  localparam int PS_DROP_MSB = 5;
  localparam int PS_DROP_LSB = 4;
  localparam int PS_ADD_MSB = 3;
  localparam int PS_ADD_LSB = 2;
  localparam int PS_PH_MSB = 1;
  // voltages in mV
  localparam logic [11:0] OVP_FLOOR_MV = 12'h708;
  localparam logic [11:0] OVP_LOW_MV = 12'h0FA;
  localparam logic [11:0] OVP_HIGH_MV = 12'h1F4;
  localparam logic [11:0] PG_HI_LOW_MV = 12'h0FA;
  localparam logic [11:0] PG_HI_HIGH_MV = 12'h12C;
  localparam logic [11:0] PG_LO_LOW_MV = 12'h12C;
  localparam logic [11:0] PG_LO_HIGH_MV = 12'h15E;
  localparam logic [11:0] PG_HYST_MV = 12'h032;
  localparam logic [11:0] OFS_STEP_MV = 12'h019;
  // pacing codes
  localparam logic [1:0] PACE_ONE = 2'h0;
  localparam logic [1:0] PACE_TWO = 2'h1;
  localparam logic [1:0] PACE_FOUR = 2'h2;
  localparam logic [1:0] PACE_ALL = 2'h3;
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_TWO = 3'h2;
  localparam logic [2:0] CYC_FOUR = 3'h4;
  localparam logic [2:0] CYC_ALL = 3'h0;
  localparam logic [1:0] PHASES_ONE = 2'h1;
  localparam logic [1:0] PHASES_TWO = 2'h2;
  localparam logic [1:0] PHASES_THREE = 2'h3;
  typedef enum logic [1:0] {
    RMP_SEL_NB = 2'b00,
    RMP_SEL_CORE = 2'b01,
    RMP_SEL_PS = 2'b10,
    RMP_SEL_NONE = 2'b11
  } rmp_sel_t;
endpackage

// >>> hw/rmp_margin_decode.sv
/*
  decodes one margin register into trip levels and signed offset.
  assumes a 12-bit mV nominal reference; purely combinational.
*/
`timescale 1ns/1ps
module rmp_margin_decode (
  // register and reference
  input wire logic [7:0] margin_in,
  input wire logic [11:0] nominal_reference_in,
  // decoded values
  output logic [11:0] overvoltage_trip_out,
  output logic [11:0] pg_upper_out,
  output logic [11:0] pg_lower_out,
  output logic signed [11:0] margin_offset_value_out
);
  logic [11:0] ovp_sum;
  logic signed [11:0] code_ext;
  always_comb begin
    ovp_sum = nominal_reference_in + (margin_in[rmp_pkg::MRG_OVP_BIT] ?
              rmp_pkg::OVP_HIGH_MV : rmp_pkg::OVP_LOW_MV);
    overvoltage_trip_out = (ovp_sum > rmp_pkg::OVP_FLOOR_MV) ? ovp_sum :
                           rmp_pkg::OVP_FLOOR_MV;
    pg_upper_out = nominal_reference_in + (margin_in[rmp_pkg::MRG_PG_BIT] ?
                   rmp_pkg::PG_HI_HIGH_MV : rmp_pkg::PG_HI_LOW_MV);
    pg_lower_out = nominal_reference_in - (margin_in[rmp_pkg::MRG_PG_BIT] ?
                   rmp_pkg::PG_LO_HIGH_MV : rmp_pkg::PG_LO_LOW_MV);
    code_ext = 12'(signed'(margin_in[rmp_pkg::MRG_OFS_MSB:0]));
    margin_offset_value_out = 12'(code_ext * signed'(rmp_pkg::OFS_STEP_MV));
  end
endmodule

// >>> hw/rmp_regs.sv
/*
  three byte registers for a dual regulator controller: margins and power save.
  assumes a serial engine presents byte writes and reads by index, synchronous.
*/
// Function
// - both margin registers share one layout, each steering only its regulator
// - bit 7 picks overvoltage trip: max(1.8V, ref+250mV or ref+500mV)
// - bit 6 picks power-good window, 250/300 or 300/350 mV; the north bridge outputs only the lower limit
// - every power-good threshold carries 50 mV hysteresis
// - bits 5..0 are a signed offset in 25 mV steps
// - power-save bits 1..0 give one, two or three active phases
// - power-save bits 5..4 pace phase drops: 1, 2, 4 cycles or all
// - power-save bits 3..2 pace phase additions: 1, 2, 4 cycles or all
// - power-save bit 6 set removes core offset during power saving
// - power-save bit 7 is reserved and steers nothing
// - register indices are 0, 1 and 2
// - reset values 00, 00, 01, also on supply-good fall
// - a completed write takes effect at once without restart
`timescale 1ns/1ps
module rmp_regs (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic clk_en_in,
  input wire logic supply_good_in,
  // register port from serial engine
  input wire logic [7:0] reg_index_in,
  input wire logic wr_strobe_in,
  input wire logic [7:0] wr_data_in,
  input wire logic rd_strobe_in,
  // regulator references
  input wire logic [11:0] nb_reference_in,
  input wire logic [11:0] core_reference_in,
  input wire logic power_save_active_in,
  // register read
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  // north-bridge parameters
  output logic [11:0] nb_ovp_out,
  output logic [11:0] nb_pg_lower_out,
  output logic [11:0] nb_pg_lower_release_out,
  output logic signed [11:0] nb_offset_out,
  // core parameters
  output logic [11:0] core_ovp_out,
  output logic [11:0] core_pg_upper_out,
  output logic [11:0] core_pg_lower_out,
  output logic [11:0] core_pg_upper_release_out,
  output logic [11:0] core_pg_lower_release_out,
  output logic signed [11:0] core_offset_out,
  // power-save parameters
  output logic [1:0] ps_phases_out,
  output logic [2:0] ps_drop_cycles_out,
  output logic [2:0] ps_add_cycles_out
);
  ////////////////////////////////////////////////////////////////////////////////
  // functions
  function automatic rmp_pkg::rmp_sel_t sel_of(input logic [7:0] idx);
    rmp_pkg::rmp_sel_t s;
    s = rmp_pkg::RMP_SEL_NONE;
    case (idx)
      rmp_pkg::IDX_NB_MARGIN: s = rmp_pkg::RMP_SEL_NB;
      rmp_pkg::IDX_CORE_MARGIN: s = rmp_pkg::RMP_SEL_CORE;
      rmp_pkg::IDX_POWER_SAVE: s = rmp_pkg::RMP_SEL_PS;
      default: s = rmp_pkg::RMP_SEL_NONE;
    endcase
    return s;
  endfunction

  function automatic logic [2:0] pace_cycles(input logic [1:0] code);
    logic [2:0] c;
    c = rmp_pkg::CYC_ONE;
    case (code)
      rmp_pkg::PACE_ONE: c = rmp_pkg::CYC_ONE;
      rmp_pkg::PACE_TWO: c = rmp_pkg::CYC_TWO;
      rmp_pkg::PACE_FOUR: c = rmp_pkg::CYC_FOUR;
      rmp_pkg::PACE_ALL: c = rmp_pkg::CYC_ALL;
      default: c = rmp_pkg::CYC_ONE;
    endcase
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // register storage
  logic [7:0] northbridge_margin_trip;
  logic [7:0] core_margin_trip;
  logic [7:0] power_save_config;
  logic [7:0] next_northbridge_margin_trip;
  logic [7:0] next_core_margin_trip;
  logic [7:0] next_power_save_config;
  logic [7:0] next_rd_data;
  logic next_rd_valid;
  rmp_pkg::rmp_sel_t sel;

  always_comb begin
    sel = sel_of(reg_index_in);
    next_northbridge_margin_trip = northbridge_margin_trip;
    next_core_margin_trip = core_margin_trip;
    next_power_save_config = power_save_config;
    next_rd_data = rd_data_out;
    next_rd_valid = 1'b0;
    if (!supply_good_in) begin
      next_northbridge_margin_trip = rmp_pkg::RST_NB_MARGIN;
      next_core_margin_trip = rmp_pkg::RST_CORE_MARGIN;
      next_power_save_config = rmp_pkg::RST_POWER_SAVE;
    end else if (wr_strobe_in) begin
      case (sel)
        rmp_pkg::RMP_SEL_NB: next_northbridge_margin_trip = wr_data_in;
        rmp_pkg::RMP_SEL_CORE: next_core_margin_trip = wr_data_in;
        rmp_pkg::RMP_SEL_PS: next_power_save_config = wr_data_in;
        default: next_power_save_config = power_save_config;
      endcase
    end
    if (rd_strobe_in) begin
      next_rd_valid = 1'b1;
      case (sel)
        rmp_pkg::RMP_SEL_NB: next_rd_data = northbridge_margin_trip;
        rmp_pkg::RMP_SEL_CORE: next_rd_data = core_margin_trip;
        rmp_pkg::RMP_SEL_PS: next_rd_data = power_save_config;
        default: next_rd_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      northbridge_margin_trip <= rmp_pkg::RST_NB_MARGIN;
      core_margin_trip <= rmp_pkg::RST_CORE_MARGIN;
      power_save_config <= rmp_pkg::RST_POWER_SAVE;
      rd_data_out <= 8'h00;
      rd_valid_out <= 1'b0;
    end else if (clk_en_in) begin
      northbridge_margin_trip <= next_northbridge_margin_trip;
      core_margin_trip <= next_core_margin_trip;
      power_save_config <= next_power_save_config;
      rd_data_out <= next_rd_data;
      rd_valid_out <= next_rd_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // decode, one instance per regulator
  logic [11:0] nb_ovp_c;
  logic [11:0] nb_pgu_c;
  logic [11:0] nb_pgl_c;
  logic signed [11:0] nb_ofs_c;
  logic [11:0] core_ovp_c;
  logic [11:0] core_pgu_c;
  logic [11:0] core_pgl_c;
  logic signed [11:0] core_ofs_c;

  rmp_margin_decode u_nb_dec (
    .margin_in(northbridge_margin_trip),
    .nominal_reference_in(nb_reference_in),
    .overvoltage_trip_out(nb_ovp_c),
    .pg_upper_out(nb_pgu_c),
    .pg_lower_out(nb_pgl_c),
    .margin_offset_value_out(nb_ofs_c)
  );

  rmp_margin_decode u_core_dec (
    .margin_in(core_margin_trip),
    .nominal_reference_in(core_reference_in),
    .overvoltage_trip_out(core_ovp_c),
    .pg_upper_out(core_pgu_c),
    .pg_lower_out(core_pgl_c),
    .margin_offset_value_out(core_ofs_c)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // registered parameter outputs
  logic [11:0] next_nb_ovp;
  logic [11:0] next_nb_pgl;
  logic [11:0] next_nb_pgl_rel;
  logic signed [11:0] next_nb_ofs;
  logic [11:0] next_core_ovp;
  logic [11:0] next_core_pgu;
  logic [11:0] next_core_pgl;
  logic [11:0] next_core_pgu_rel;
  logic [11:0] next_core_pgl_rel;
  logic signed [11:0] next_core_ofs;
  logic [1:0] next_phases;
  logic [2:0] next_drop;
  logic [2:0] next_add;

  always_comb begin
    next_nb_ovp = nb_ovp_c;
    next_nb_pgl = nb_pgl_c;
    next_nb_pgl_rel = nb_pgl_c + rmp_pkg::PG_HYST_MV;
    next_nb_ofs = nb_ofs_c;
    next_core_ovp = core_ovp_c;
    next_core_pgu = core_pgu_c;
    next_core_pgl = core_pgl_c;
    next_core_pgu_rel = core_pgu_c - rmp_pkg::PG_HYST_MV;
    next_core_pgl_rel = core_pgl_c + rmp_pkg::PG_HYST_MV;
    next_core_ofs = core_ofs_c;
    if (power_save_active_in && power_save_config[rmp_pkg::PS_OFS_DIS_BIT]) begin
      next_core_ofs = 12'sh000;
    end
    next_phases = power_save_config[rmp_pkg::PS_PH_MSB] ? rmp_pkg::PHASES_THREE :
                  (power_save_config[0] ? rmp_pkg::PHASES_TWO : rmp_pkg::PHASES_ONE);
    next_drop = pace_cycles(power_save_config[rmp_pkg::PS_DROP_MSB:rmp_pkg::PS_DROP_LSB]);
    next_add = pace_cycles(power_save_config[rmp_pkg::PS_ADD_MSB:rmp_pkg::PS_ADD_LSB]);
    // bit PS_RSVD_BIT is stored and read back only
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      nb_ovp_out <= rmp_pkg::OVP_FLOOR_MV;
      nb_pg_lower_out <= 12'h000;
      nb_pg_lower_release_out <= 12'h000;
      nb_offset_out <= 12'sh000;
      core_ovp_out <= rmp_pkg::OVP_FLOOR_MV;
      core_pg_upper_out <= 12'h000;
      core_pg_lower_out <= 12'h000;
      core_pg_upper_release_out <= 12'h000;
      core_pg_lower_release_out <= 12'h000;
      core_offset_out <= 12'sh000;
      ps_phases_out <= rmp_pkg::PHASES_TWO;
      ps_drop_cycles_out <= rmp_pkg::CYC_ONE;
      ps_add_cycles_out <= rmp_pkg::CYC_ONE;
    end else if (clk_en_in) begin
      nb_ovp_out <= next_nb_ovp;
      nb_pg_lower_out <= next_nb_pgl;
      nb_pg_lower_release_out <= next_nb_pgl_rel;
      nb_offset_out <= next_nb_ofs;
      core_ovp_out <= next_core_ovp;
      core_pg_upper_out <= next_core_pgu;
      core_pg_lower_out <= next_core_pgl;
      core_pg_upper_release_out <= next_core_pgu_rel;
      core_pg_lower_release_out <= next_core_pgl_rel;
      core_offset_out <= next_core_ofs;
      ps_phases_out <= next_phases;
      ps_drop_cycles_out <= next_drop;
      ps_add_cycles_out <= next_add;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);

  sequence s_ps_write(logic [7:0] d);
    clk_en_in && supply_good_in && wr_strobe_in &&
    reg_index_in == rmp_pkg::IDX_POWER_SAVE && wr_data_in == d;
  endsequence

  AST_SUPPLY_RESET: assert property (clk_en_in && !supply_good_in |=>
    power_save_config == rmp_pkg::RST_POWER_SAVE && core_margin_trip == 8'h00)
    else $error("registers not restored on supply fall");
  AST_NB_WRITE: assert property (clk_en_in && supply_good_in && wr_strobe_in &&
    reg_index_in == rmp_pkg::IDX_NB_MARGIN |=> northbridge_margin_trip == $past(wr_data_in))
    else $error("north-bridge write lost");
  AST_CORE_ISOLATED: assert property (clk_en_in && supply_good_in && wr_strobe_in &&
    reg_index_in == rmp_pkg::IDX_CORE_MARGIN |=> $stable(northbridge_margin_trip))
    else $error("core write disturbed north-bridge");
  AST_IMMEDIATE: assert property (s_ps_write(8'h03) ##1 clk_en_in |=>
    ps_phases_out == rmp_pkg::PHASES_THREE)
    else $error("phase count not updated");
  AST_DROP_ALL: assert property (s_ps_write(8'h30) ##1 clk_en_in |=>
    ps_drop_cycles_out == rmp_pkg::CYC_ALL)
    else $error("drop pacing wrong");
  AST_ADD_FOUR: assert property (s_ps_write(8'h08) ##1 clk_en_in |=>
    ps_add_cycles_out == rmp_pkg::CYC_FOUR)
    else $error("add pacing wrong");
  AST_ONE_PHASE: assert property (s_ps_write(8'h00) ##1 clk_en_in |=>
    ps_phases_out == rmp_pkg::PHASES_ONE)
    else $error("single phase not selected");
  AST_OFS_DIS: assert property (clk_en_in && power_save_active_in &&
    power_save_config[rmp_pkg::PS_OFS_DIS_BIT] |=> core_offset_out == 12'sh000)
    else $error("core offset not removed");
  AST_HYST: assert property (clk_en_in |=>
    core_pg_lower_release_out == core_pg_lower_out + rmp_pkg::PG_HYST_MV)
    else $error("hysteresis missing");
  AST_OVP_FLOOR: assert property (nb_ovp_out >= rmp_pkg::OVP_FLOOR_MV)
    else $error("overvoltage trip below floor");
  AST_RSVD: assert property (clk_en_in &&
    $changed(power_save_config[rmp_pkg::PS_RSVD_BIT]) && $stable(power_save_config[6:0]) &&
    $stable(power_save_active_in) && $stable(core_margin_trip) |=>
    $stable(ps_phases_out) && $stable(core_offset_out))
    else $error("reserved bit steered logic");
  AST_OFS_STEP: assert property (clk_en_in && core_margin_trip[5:0] == 6'h20 &&
    !power_save_active_in |=> core_offset_out == -12'sd800)
    else $error("offset code scale wrong");
  AST_PG_WIN: assert property (clk_en_in && core_margin_trip[rmp_pkg::MRG_PG_BIT] |=>
    core_pg_upper_out == $past(core_reference_in) + rmp_pkg::PG_HI_HIGH_MV)
    else $error("power-good window wrong");
  AST_NB_HYST: assert property (clk_en_in |=>
    nb_pg_lower_release_out == nb_pg_lower_out + rmp_pkg::PG_HYST_MV)
    else $error("north-bridge hysteresis missing");
  AST_UPPER_HYST: assert property (clk_en_in |=>
    core_pg_upper_release_out == core_pg_upper_out - rmp_pkg::PG_HYST_MV)
    else $error("upper hysteresis missing");
  AST_NB_PG_WIN: assert property (clk_en_in &&
    !northbridge_margin_trip[rmp_pkg::MRG_PG_BIT] |=>
    nb_pg_lower_out == $past(nb_reference_in) - rmp_pkg::PG_LO_LOW_MV)
    else $error("north-bridge power-good limit wrong");
  AST_RD_VALID: assert property (clk_en_in && rd_strobe_in |=> rd_valid_out)
    else $error("read not answered");
  AST_RD_NONE: assert property (clk_en_in && rd_strobe_in &&
    reg_index_in > rmp_pkg::IDX_POWER_SAVE |=> rd_data_out == 8'h00)
    else $error("unmapped index read not zero");
endmodule

// >>> test/rmp_master_model.sv
/*
  serial-engine side model: byte writes and reads by register index.
  assumes the bank samples strobes on clk_sys_in rising edges.
*/
`timescale 1ns/1ps
module rmp_master_model (
  // clock
  input wire logic clk_sys_in,
  // register port
  output logic [7:0] reg_index_out,
  output logic wr_strobe_out,
  output logic [7:0] wr_data_out,
  output logic rd_strobe_out,
  input wire logic [7:0] rd_data_in,
  input wire logic rd_valid_in
);
  initial begin
    reg_index_out = 8'h00;
    wr_strobe_out = 1'b0;
    wr_data_out = 8'h00;
    rd_strobe_out = 1'b0;
  end
  // one write by index, lines scrambled after release
  task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
    @(posedge clk_sys_in);
    #2;
    reg_index_out = idx;
    wr_data_out = dat;
    wr_strobe_out = 1'b1;
    @(posedge clk_sys_in);
    #2;
    wr_strobe_out = 1'b0;
    wr_data_out = ~dat;
    reg_index_out = ~idx;
  endtask
  // one read by index, answer taken after the taking edge
  task automatic rd(input logic [7:0] idx, output logic [7:0] dat, output logic ok);
    @(posedge clk_sys_in);
    #2;
    reg_index_out = idx;
    rd_strobe_out = 1'b1;
    @(posedge clk_sys_in);
    #2;
    rd_strobe_out = 1'b0;
    reg_index_out = ~idx;
    ok = rd_valid_in;
    dat = rd_data_in;
  endtask
endmodule

// >>> test/regulator_margin_powersave_regs_test.sv
/*
  self-checking bench for the margin and power-save register bank.
  assumes the master model drives the register port.
*/
`timescale 1ns/1ps
module regulator_margin_powersave_regs_test;
  logic clk_sys_in, rstn_in, clk_en_in, supply_good_in, psa;
  logic [11:0] nb_ref, core_ref;
  logic [7:0] idx, wdat, rdat, rv;
  logic wstb, rstb, rval, ok;
  logic [11:0] nb_ovp, nb_pgl, nb_pglr, nb_ofs;
  logic [11:0] c_ovp, c_pgu, c_pgl, c_pgur, c_pglr, c_ofs;
  logic [1:0] phases;
  logic [2:0] drop_cyc, add_cyc;
  logic [7:0] cm;
  int errors, cmp_count;
  logic [7:0] rst_v[3] = '{8'h00, 8'h00, 8'h01};
  logic [7:0] mv[4] = '{8'h20, 8'h9F, 8'h77, 8'hF8};
  logic [7:0] pv[9] = '{8'h00, 8'h03, 8'h30, 8'h08, 8'h15, 8'h2A, 8'h3F, 8'hC4, 8'h44};

  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end

  rmp_regs dut_u (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .clk_en_in(clk_en_in),
    .supply_good_in(supply_good_in), .reg_index_in(idx), .wr_strobe_in(wstb),
    .wr_data_in(wdat), .rd_strobe_in(rstb), .nb_reference_in(nb_ref),
    .core_reference_in(core_ref), .power_save_active_in(psa), .rd_data_out(rdat),
    .rd_valid_out(rval), .nb_ovp_out(nb_ovp), .nb_pg_lower_out(nb_pgl),
    .nb_pg_lower_release_out(nb_pglr), .nb_offset_out(nb_ofs), .core_ovp_out(c_ovp),
    .core_pg_upper_out(c_pgu), .core_pg_lower_out(c_pgl),
    .core_pg_upper_release_out(c_pgur), .core_pg_lower_release_out(c_pglr),
    .core_offset_out(c_ofs), .ps_phases_out(phases), .ps_drop_cycles_out(drop_cyc),
    .ps_add_cycles_out(add_cyc));

  rmp_master_model master_u (.clk_sys_in(clk_sys_in), .reg_index_out(idx),
    .wr_strobe_out(wstb), .wr_data_out(wdat), .rd_strobe_out(rstb),
    .rd_data_in(rdat), .rd_valid_in(rval));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [11:0] overvoltage_trip(input logic [11:0] r, input logic b);
    logic [11:0] t;
    t = r + (b ? 12'h1F4 : 12'h0FA);
    return (t > 12'h708) ? t : 12'h708;
  endfunction
  function automatic logic [11:0] ofs(input logic [7:0] v);
    return {{6{v[5]}}, v[5:0]} * 12'h019;
  endfunction
  function automatic logic [11:0] cyc(input logic [1:0] c);
    return (c == 2'h3) ? 12'h000 : (12'h001 << c);
  endfunction

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] i, input logic [7:0] exp);
    master_u.rd(i, rv, ok);
    chk(12'(ok), 12'h001);
    chk(12'(rv), 12'(exp));
  endtask
  task automatic settle;
    repeat (2) @(posedge clk_sys_in);
    #2;
  endtask

  task automatic wrap_up;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(25 * 4000);
    errors++;
    wrap_up();
  end

  initial begin
    errors = 0;
    cmp_count = 0;
    rstn_in = 1'b0;
    clk_en_in = 1'b1;
    supply_good_in = 1'b1;
    psa = 1'b0;
    nb_ref = 12'h3E8;
    core_ref = 12'h640;
    repeat (10) @(posedge clk_sys_in);
    #2;
    rstn_in = 1'b1;
    for (int i = 0; i < 3; i++) rdchk(8'(i), rst_v[i]);
    chk(12'(phases), 12'h002);
    chk(12'(drop_cyc), 12'h001);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      nb_ref = i[0] ? 12'h3E8 : 12'h6A4;
      cm = mv[i] ^ 8'hC0;
      master_u.wr(8'h00, mv[i]);
      master_u.wr(8'h01, cm);
      settle();
      chk(nb_ovp, overvoltage_trip(nb_ref, mv[i][7]));
      chk(nb_pgl, nb_ref - (mv[i][6] ? 12'h15E : 12'h12C));
      chk(nb_pglr, nb_ref - (mv[i][6] ? 12'h15E : 12'h12C) + 12'h032);
      chk(nb_ofs, ofs(mv[i]));
      chk(c_ovp, overvoltage_trip(core_ref, cm[7]));
      chk(c_pgu, core_ref + (cm[6] ? 12'h12C : 12'h0FA));
      chk(c_pgl, core_ref - (cm[6] ? 12'h15E : 12'h12C));
      chk(c_pgur, core_ref + (cm[6] ? 12'h12C : 12'h0FA) - 12'h032);
      chk(c_pglr, core_ref - (cm[6] ? 12'h15E : 12'h12C) + 12'h032);
      chk(c_ofs, ofs(cm));
      rdchk(8'h00, mv[i]);
      rdchk(8'h01, cm);
    end
    $display("test margins done");
    for (int i = 0; i < 9; i++) begin
      master_u.wr(8'h02, pv[i]);
      psa = pv[i][6];
      settle();
      chk(12'(phases), pv[i][1] ? 12'h003 : (pv[i][0] ? 12'h002 : 12'h001));
      chk(12'(drop_cyc), cyc(pv[i][5:4]));
      chk(12'(add_cyc), cyc(pv[i][3:2]));
      chk(c_ofs, (pv[i][6] && psa) ? 12'h000 : ofs(cm));
      rdchk(8'h02, pv[i]);
    end
    $display("test power save done");
    master_u.wr(8'h03, 8'h55);
    rdchk(8'h03, 8'h00);
    rdchk(8'h02, 8'h44);
    clk_en_in = 1'b0;
    master_u.wr(8'h00, 8'h11);
    clk_en_in = 1'b1;
    rdchk(8'h00, mv[3]);
    $display("test refusals done");
    supply_good_in = 1'b0;
    @(posedge clk_sys_in);
    #2;
    supply_good_in = 1'b1;
    for (int i = 0; i < 3; i++) rdchk(8'(i), rst_v[i]);
    $display("test supply fall done");
    wrap_up();
  end
endmodule
